/* File: common/port3_pkg.sv */
// port3_pkg: register map, field positions, reset values and line numbers of the port 3 block
// assumes a 32-bit AXI4-Lite register bus; printed offsets are word indices, byte address = index * 4
package port3_pkg;

  // bus widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int REG_W  = 16;

  // register indices as printed, and their byte addresses
  localparam logic [15:0] IDX_PIN_DATA    = 16'hFFC4;
  localparam logic [15:0] IDX_DIRECTION   = 16'hFFC6;
  localparam logic [15:0] IDX_DRIVE_STYLE = 16'hF1C6;
  localparam logic [15:0] IDX_CONTROL     = 16'hF1D0;
  localparam logic [17:0] ADDR_PIN_DATA    = {IDX_PIN_DATA, 2'b00};
  localparam logic [17:0] ADDR_DIRECTION   = {IDX_DIRECTION, 2'b00};
  localparam logic [17:0] ADDR_DRIVE_STYLE = {IDX_DRIVE_STYLE, 2'b00};
  localparam logic [17:0] ADDR_CONTROL     = {IDX_CONTROL, 2'b00};

  // reset values
  localparam logic [15:0] RST_PIN_DATA    = 16'h0000;
  localparam logic [15:0] RST_DIRECTION   = 16'h0000;
  localparam logic [15:0] RST_DRIVE_STYLE = 16'h0000;
  localparam logic        RST_SYSTEM_CLOCK_OUTPUT_EN   = 1'b0;
  localparam logic        RST_BYTE_HIGH_DISABLE = 1'b0;
  localparam logic        RST_WRITE_CONFIG      = 1'b0;

  // implemented bits: line 14 has no pin, lines 15, 14, 12 have no open-drain bit
  localparam logic [15:0] DIR_MASK    = 16'hBFFF;
  localparam logic [15:0] OD_MASK     = 16'h2FFF;
  localparam logic [15:0] NO_PIN_MASK = 16'h4000;

  // control register fields
  localparam int CTL_SYSTEM_CLOCK_OUTPUT_EN         = 0;
  localparam int CTL_BYTE_HIGH_DISABLE = 1;
  localparam int CTL_WRITE_CONFIG      = 2;
  localparam int CTL_STROBE_ACTIVE     = 3;
  localparam int CTL_HOLD              = 4;

  // line numbers
  localparam int LINE_TIMER0_IN = 0;
  localparam int LINE_CAPTURE   = 2;
  localparam int LINE_T3_UPDOWN = 4;
  localparam int LINE_T4_IN     = 5;
  localparam int LINE_T3_IN     = 6;
  localparam int LINE_T2_IN     = 7;
  localparam int LINE_SYNC_RX   = 8;
  localparam int LINE_SYNC_TX   = 9;
  localparam int LINE_ASYNC_RX  = 11;
  localparam int LINE_STROBE    = 12;
  localparam int LINE_SHIFT_CLK = 13;
  localparam int LINE_SYSTEM_CLOCK_OUTPUT    = 15;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                             input logic [1:0] strb);
    lane_merge = {strb[1] ? new_v[15:8] : old_v[15:8], strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : lane_merge

endpackage : port3_pkg

/* File: hw/port3_axil_slave.sv */
// port3_axil_slave: AXI4-Lite slave front end for the port 3 registers
// assumes one clock, synchronous active-low reset; decode and read data come from the parent
`timescale 1ns/10ps
`default_nettype none
module port3_axil_slave
  import port3_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output var  logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              wr_en_out,
  output var  logic [ADDR_W-1:0] wr_addr_out,
  output var  logic [DATA_W-1:0] wr_data_out,
  output var  logic [3:0]        wr_strb_out,
  input  wire logic              wr_hit_in,
  output var  logic [ADDR_W-1:0] rd_addr_out,
  input  wire logic [DATA_W-1:0] rd_data_in,
  input  wire logic              rd_hit_in
);

  logic rd_pend_q;

  // write fires once address and data are both held and no response is pending
  assign wr_en_out = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // write address and data, taken in either order
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_addr_out   <= '0;
      wr_data_out   <= '0;
      wr_strb_out   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr_out   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data_out  <= s_axi_wdata;
        wr_strb_out  <= s_axi_wstrb;
      end
      if (wr_en_out) begin
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_hit_in ? RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read: address taken, data one cycle later, held until rready
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
      rd_addr_out   <= '0;
      rd_pend_q     <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        rd_addr_out   <= s_axi_araddr;
        rd_pend_q     <= 1'b1;
      end else if (rd_pend_q) begin
        rd_pend_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit_in ? rd_data_in : '0;
        s_axi_rresp  <= rd_hit_in ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : port3_axil_slave
`default_nettype wire

/* File: hw/port3_io.sv */
// port3_io: 15-line general purpose port with alternate peripheral functions
// assumes synchronous pins and peripheral signals on clock_in; pin wire resolution done outside
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// [R1] fifteen lines; direction bit 0 floats the line, 1 drives it
// [R2] drive-style bit 0 gives push-pull, 1 gives open-drain
// [R3] lines 15, 14 and 12 have no open-drain bit
// [R4] data bit 14 is stored but drives no pin
// [R5] alternate inputs read the input latch of their pin
// [R6] alternate output is ANDed with the data latch before the driver
// [R7] software sets direction and latch to one before using an alternate output
// [R8] an unused alternate output rests high so the pin follows the latch
// [R9] alternate outputs: timer 6, timer 3, async transmit, byte-high strobe, clock out
// [R10] software sets direction to match bidirectional peripheral modes
// [R11] lines 0, 2, 4, 5, 6, 7 feed timer and capture inputs
// [R12] clock output enable drives line 15 regardless of its direction bit
// [R13] after reset line 12 carries the strobe chosen by the start-up configuration
// [R14] line 12 becomes plain I/O when byte-high disable is 1 and write config 0
// [R15] strobe function drives line 12 regardless of its direction bit
// [R16] during bus hold line 12 follows its direction and data bits
module port3_io
  import port3_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              nrst_in,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output var  logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output var  logic [DATA_W-1:0] s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  input  wire logic [15:0]       pin_in,
  output var  logic [15:0]       pin_out,
  output var  logic [15:0]       pin_oe_out,
  input  wire logic              startup_write_high_in,
  input  wire logic              bus_hold_in,
  input  wire logic              timer6_toggle_output_in,
  input  wire logic              timer3_toggle_output_in,
  input  wire logic              async_serial_transmit_in,
  input  wire logic              async_serial_receive_alt_in,
  input  wire logic              sync_serial_master_receive_alt_in,
  input  wire logic              sync_serial_master_transmit_alt_in,
  input  wire logic              sync_shift_clock_alt_in,
  input  wire logic              byte_high_write_high_strobe_in,
  input  wire logic              system_clock_output_in,
  output var  logic              timer0_count_input_out,
  output var  logic              capture_input_out,
  output var  logic              timer3_up_down_input_out,
  output var  logic              timer4_count_input_out,
  output var  logic              timer3_count_input_out,
  output var  logic              timer2_count_input_out,
  output var  logic              sync_serial_master_receive_out,
  output var  logic              sync_serial_master_transmit_out,
  output var  logic              async_serial_receive_out,
  output var  logic              sync_shift_clock_out
);

  logic [15:0]       data_q;
  logic [15:0]       dir_q;
  logic [15:0]       od_q;
  logic [15:0]       in_q;
  logic              clk_en_q;
  logic              byte_high_disable_bit_q;
  logic              write_configuration_bit_q;
  logic              started_q;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              wr_hit;
  logic              rd_hit;

  // bus front end
  port3_axil_slave u_slave (
    .clock_in      (clock_in),
    .nrst_in       (nrst_in),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wr_en_out     (wr_en),
    .wr_addr_out   (wr_addr),
    .wr_data_out   (wr_data),
    .wr_strb_out   (wr_strb),
    .wr_hit_in     (wr_hit),
    .rd_addr_out   (rd_addr),
    .rd_data_in    (rd_data),
    .rd_hit_in     (rd_hit)
  );

  // write address decode
  wire wr_data_sel = wr_en && (wr_addr == ADDR_PIN_DATA);
  wire wr_dir_sel  = wr_en && (wr_addr == ADDR_DIRECTION);
  wire wr_od_sel   = wr_en && (wr_addr == ADDR_DRIVE_STYLE);
  wire wr_ctl_sel  = wr_en && (wr_addr == ADDR_CONTROL);
  assign wr_hit = (wr_addr == ADDR_PIN_DATA) || (wr_addr == ADDR_DIRECTION) ||
                  (wr_addr == ADDR_DRIVE_STYLE) || (wr_addr == ADDR_CONTROL);
  wire [15:0] ctl_new = lane_merge(16'h0000, wr_data[15:0], wr_strb[1:0]);

  // line 12 strobe selected unless disabled, and released during bus hold
  wire strobe_en  = !(byte_high_disable_bit_q && !write_configuration_bit_q);                // [R14]
  wire strobe_sel = strobe_en && !bus_hold_in;              // [R16]

  // control view for reads
  wire [15:0] ctl_view = {11'h000, bus_hold_in, strobe_en, write_configuration_bit_q, byte_high_disable_bit_q, clk_en_q};

  // read decode: data register shows pin state, bit 14 shows its latch
  assign rd_hit = (rd_addr == ADDR_PIN_DATA) || (rd_addr == ADDR_DIRECTION) ||
                  (rd_addr == ADDR_DRIVE_STYLE) || (rd_addr == ADDR_CONTROL);
  wire [15:0] rd_val = (rd_addr == ADDR_PIN_DATA)    ? ((in_q & ~NO_PIN_MASK) | (data_q & NO_PIN_MASK)) :
                       (rd_addr == ADDR_DIRECTION)   ? dir_q :
                       (rd_addr == ADDR_DRIVE_STYLE) ? od_q :
                       (rd_addr == ADDR_CONTROL)     ? ctl_view : 16'h0000;
  assign rd_data = {16'h0000, rd_val};

  // port registers; open-drain bits 15, 14, 12 stay zero
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      data_q <= RST_PIN_DATA;
      dir_q  <= RST_DIRECTION;
      od_q   <= RST_DRIVE_STYLE;
    end else begin
      if (wr_data_sel) data_q <= lane_merge(data_q, wr_data[15:0], wr_strb[1:0]);  // [R4]
      if (wr_dir_sel)  dir_q  <= lane_merge(dir_q, wr_data[15:0], wr_strb[1:0]) & DIR_MASK;  // [R1]
      if (wr_od_sel)   od_q   <= lane_merge(od_q, wr_data[15:0], wr_strb[1:0]) & OD_MASK;  // [R2] [R3]
    end
  end

  // control bits; start-up strobe mode caught at the first edge after reset release
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      clk_en_q  <= RST_SYSTEM_CLOCK_OUTPUT_EN;
      byte_high_disable_bit_q  <= RST_BYTE_HIGH_DISABLE;
      write_configuration_bit_q   <= RST_WRITE_CONFIG;
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
      if (!started_q) begin
        write_configuration_bit_q <= startup_write_high_in;  // [R13]
      end else if (wr_ctl_sel) begin
        if (wr_strb[0]) begin
          clk_en_q <= ctl_new[CTL_SYSTEM_CLOCK_OUTPUT_EN];
          byte_high_disable_bit_q <= ctl_new[CTL_BYTE_HIGH_DISABLE];
          write_configuration_bit_q  <= ctl_new[CTL_WRITE_CONFIG];
        end
      end
    end
  end

  // alternate outputs per line; idle peripherals hold their line high
  wire [15:0] alt_out = {2'b11, sync_shift_clock_alt_in, 1'b1, async_serial_receive_alt_in,
                         async_serial_transmit_in, sync_serial_master_transmit_alt_in,
                         sync_serial_master_receive_alt_in, 4'hF, timer3_toggle_output_in, 1'b1,
                         timer6_toggle_output_in, 1'b1};  // [R8] [R9]
  wire [15:0] anded   = data_q & alt_out;  // [R6]

  // lines 15 and 12 select their function directly, with a forced driver
  wire line15_val = clk_en_q ? system_clock_output_in : anded[LINE_SYSTEM_CLOCK_OUTPUT];
  wire line12_val = strobe_sel ? byte_high_write_high_strobe_in : anded[LINE_STROBE];
  wire [15:0] value = {line15_val, anded[14:13], line12_val, anded[11:0]};
  wire [15:0] force_drv = {clk_en_q, 2'b00, strobe_sel, 12'h000};  // [R12] [R15]
  wire [15:0] drive = (dir_q | force_drv) & ~NO_PIN_MASK;  // [R1] [R4]

  // pin drivers: open-drain lines only pull low
  wire [15:0] oe_d  = drive & ~(od_q & value);  // [R2]
  wire [15:0] out_d = drive & value & ~od_q;

  // registered pins and input latch
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      pin_out    <= 16'h0000;
      pin_oe_out <= 16'h0000;
      in_q       <= 16'h0000;
    end else begin
      pin_out    <= out_d;
      pin_oe_out <= oe_d;
      in_q       <= pin_in;  // [R5]
    end
  end

  // peripheral inputs read the input latch
  assign timer0_count_input_out          = in_q[LINE_TIMER0_IN];  // [R5] [R11]
  assign capture_input_out               = in_q[LINE_CAPTURE];  // [R11]
  assign timer3_up_down_input_out        = in_q[LINE_T3_UPDOWN];  // [R11]
  assign timer4_count_input_out          = in_q[LINE_T4_IN];  // [R11]
  assign timer3_count_input_out          = in_q[LINE_T3_IN];  // [R11]
  assign timer2_count_input_out          = in_q[LINE_T2_IN];  // [R11]
  assign sync_serial_master_receive_out  = in_q[LINE_SYNC_RX];
  assign sync_serial_master_transmit_out = in_q[LINE_SYNC_TX];
  assign async_serial_receive_out        = in_q[LINE_ASYNC_RX];
  assign sync_shift_clock_out            = in_q[LINE_SHIFT_CLK];

  // checks on pin behaviour
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  dir_input_float_a: assert property ((dir_q[0] == 1'b0) |=> !pin_oe_out[0])  // [R1]
    else $error("input line 0 is driven");
  drive_style_a: assert property (dir_q[5] && od_q[5] |=> !(pin_oe_out[5] && pin_out[5]))  // [R2]
    else $error("open-drain line drives high");
  od_bits_absent_a: assert property (od_q[15] == 1'b0 && od_q[14] == 1'b0 && od_q[12] == 1'b0)  // [R3]
    else $error("missing open-drain bit is set");
  no_pin_line_a: assert property (##1 !pin_oe_out[14] && !pin_out[14])  // [R4]
    else $error("line 14 drives a pin");
  input_latch_a: assert property (pin_in[LINE_T2_IN] |=> timer2_count_input_out)  // [R5] [R11]
    else $error("timer 2 input does not follow its pin");
  alt_and_a: assert property (dir_q[3] && !od_q[3] && !timer3_toggle_output_in |=> pin_oe_out[3] && !pin_out[3])  // [R6]
    else $error("timer 3 toggle not ANDed onto pin");
  alt_idle_a: assert property (dir_q[1] && !od_q[1] && timer6_toggle_output_in |=> pin_out[1] == $past(data_q[1]))  // [R8]
    else $error("idle alternate output changes pin");
  system_clock_output_force_a: assert property (clk_en_q && !dir_q[15] |=> pin_oe_out[15] && pin_out[15] == $past(system_clock_output_in))  // [R12]
    else $error("clock output not driven");
  reset_strobe_a: assert property ($rose(nrst_in) |-> strobe_en ##1 strobe_en)  // [R13]
    else $error("strobe not selected after reset");
  gpio_release_a: assert property (byte_high_disable_bit_q && !write_configuration_bit_q && !dir_q[12] |=> !pin_oe_out[12])  // [R14]
    else $error("line 12 driven after release to I/O");
  strobe_force_a: assert property (strobe_en && !bus_hold_in |=> pin_oe_out[12])  // [R15]
    else $error("strobe line not driven");
  hold_release_a: assert property (bus_hold_in && !dir_q[12] |=> !pin_oe_out[12])  // [R16]
    else $error("line 12 driven during hold");

  system_clock_output_seen_c: cover property (clk_en_q ##1 pin_oe_out[15]);
  gpio_mode_c:   cover property (wr_ctl_sel ##1 !strobe_en);
  hold_seen_c:   cover property (strobe_en && bus_hold_in);

endmodule : port3_io
`default_nettype wire

/* File: tb/port3_board.sv */
// port3_board: board circuitry on the port 3 pins, pull-ups and one external driver
// assumes pin values and enables from the port; the board drives only where told to
`timescale 1ns/10ps
`default_nettype none
module port3_board (
  input  wire logic [15:0] pin_out_in,
  input  wire logic [15:0] pin_oe_in,
  input  wire logic [15:0] ext_en_in,
  input  wire logic [15:0] ext_val_in,
  output var  logic [15:0] level_out
);
  // wire level: port driver, else board driver, else pull-up (open-drain high floats up)
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      level_out[i] = pin_oe_in[i] ? pin_out_in[i] : (ext_en_in[i] ? ext_val_in[i] : 1'b1);
    end
  end
endmodule : port3_board
`default_nettype wire

/* File: tb/port3_io_with_alternate_functions_tb.sv */
// port3_io_with_alternate_functions_tb: self-checking bench for the port 3 block
// assumes the port3_pkg register map; pins resolved by the board model
`timescale 1ns/10ps
`default_nettype none
module port3_io_with_alternate_functions_tb;
  import port3_pkg::*;
  logic              clock_in = 1'b0, nrst_in = 1'b0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [15:0]       pin_in, pin_out, pin_oe_out, ext_en = '0, ext_val = '0, d, r, v;
  logic              strap = 1'b0, hold = 1'b0, strobe = 1'b1, system_clock_output = 1'b1;
  logic [6:0]        alt = 7'h7F;
  logic [9:0]        tap;
  logic [31:0]       lfsr = 32'h33ED95DC;
  logic [33:0]       note_r;
  logic [33:0]       exp_r[$];
  logic [1:0]        exp_b[$];
  int                fail_count = 0, samples_checked = 0;
  localparam int     ALT_LINE[7] = '{1, 3, 10, 8, 9, 11, 13};

  always #10 clock_in = ~clock_in;

  port3_io dut (
    .clock_in, .nrst_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .pin_in, .pin_out, .pin_oe_out, .startup_write_high_in(strap), .bus_hold_in(hold),
    .timer6_toggle_output_in(alt[0]), .timer3_toggle_output_in(alt[1]), .async_serial_transmit_in(alt[2]),
    .sync_serial_master_receive_alt_in(alt[3]), .sync_serial_master_transmit_alt_in(alt[4]),
    .async_serial_receive_alt_in(alt[5]), .sync_shift_clock_alt_in(alt[6]),
    .byte_high_write_high_strobe_in(strobe), .system_clock_output_in(system_clock_output),
    .timer0_count_input_out(tap[0]), .capture_input_out(tap[1]), .timer3_up_down_input_out(tap[2]),
    .timer4_count_input_out(tap[3]), .timer3_count_input_out(tap[4]), .timer2_count_input_out(tap[5]),
    .sync_serial_master_receive_out(tap[6]), .sync_serial_master_transmit_out(tap[7]),
    .async_serial_receive_out(tap[8]), .sync_shift_clock_out(tap[9]));

  port3_board board (.pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .ext_en_in(ext_en),
                     .ext_val_in(ext_val), .level_out(pin_in));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    check_word(what, {30'h0, exp}, {30'h0, got});
  endtask : check_resp

  task automatic check_pins(input logic [15:0] exp_oe, input logic [15:0] exp_out);
    check_word("pin enables", {16'h0, exp_oe}, {16'h0, pin_oe_out});
    check_word("pin values", {16'h0, exp_out}, {16'h0, pin_out});
  endtask : check_pins

  task automatic settle;
    repeat (3) @(posedge clock_in);
  endtask : settle

  // write master: address and data together, each released when taken
  task automatic bus_write(input logic [17:0] a, input logic [15:0] wd, input logic [1:0] resp = RESP_OKAY);
    logic aw_open, w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    exp_b.push_back(resp);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0, wd};
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clock_in);
      if (aw_open && s_axi_awready) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_open && s_axi_wready) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid);
  endtask : bus_write

  // read master: note the expected word, wait for the answer
  task automatic bus_read(input logic [17:0] a, input logic [31:0] rd, input logic [1:0] resp = RESP_OKAY);
    logic ar_open;
    ar_open = 1'b1;
    exp_r.push_back({resp, rd});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clock_in);
      if (ar_open && s_axi_arready) begin
        ar_open = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (!s_axi_rvalid);
  endtask : bus_read

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // response monitor: oldest note against each handshake
  always @(posedge clock_in) begin
    if (s_axi_rvalid && s_axi_rready && exp_r.size() > 0) begin
      note_r = exp_r.pop_front();
      check_word("read data", note_r[31:0], s_axi_rdata);
      check_resp("read response", note_r[33:32], s_axi_rresp);
    end
    if (s_axi_bvalid && s_axi_bready && exp_b.size() > 0) begin
      check_resp("write response", exp_b.pop_front(), s_axi_bresp);
    end
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    stop_test();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock_in);
    nrst_in <= 1'b1;
    settle();
    check_pins(16'h1000, 16'h1000);
    strobe <= 1'b0;
    settle();
    check_pins(16'h1000, 16'h0000);
    strobe <= 1'b1;
    settle();
    bus_read(ADDR_PIN_DATA, 32'h0000BFFF);
    bus_read(ADDR_DIRECTION, 32'h0);
    bus_read(ADDR_DRIVE_STYLE, 32'h0);
    bus_read(ADDR_CONTROL, 32'h8);
    bus_read(18'h00100, 32'h0, RESP_SLVERR);
    bus_write(18'h00100, 16'hFFFF, RESP_SLVERR);
    bus_write(ADDR_CONTROL, 16'h0002);
    settle();
    bus_read(ADDR_CONTROL, 32'h2);
    check_pins(16'h0000, 16'h0000);
    repeat (4) begin
      lfsr = next_rand(lfsr);
      d = lfsr[15:0];
      r = lfsr[31:16];
      bus_write(ADDR_PIN_DATA, d);
      bus_write(ADDR_DIRECTION, r);
      settle();
      check_pins(r & 16'hBFFF, d & r & 16'hBFFF);
      bus_read(ADDR_DIRECTION, {16'h0, r & 16'hBFFF});
      bus_read(ADDR_PIN_DATA, {16'h0, ((d | ~r) & 16'hBFFF) | (d & 16'h4000)});
    end
    // alternate outputs set up as software must: latch and direction at one
    bus_write(ADDR_PIN_DATA, 16'hFFFF);
    bus_write(ADDR_DIRECTION, 16'hBFFF);
    for (int k = 0; k < 7; k++) begin
      alt[k] <= 1'b0;
      settle();
      check_pins(16'hBFFF, 16'hBFFF & ~(16'h1 << ALT_LINE[k]));
      alt[k] <= 1'b1;
    end
    bus_write(ADDR_DRIVE_STYLE, 16'hFFFF);
    bus_read(ADDR_DRIVE_STYLE, 32'h2FFF);
    lfsr = next_rand(lfsr);
    d = lfsr[15:0];
    bus_write(ADDR_PIN_DATA, d);
    settle();
    check_pins(16'hBFFF & ~(16'h2FFF & d), d & 16'h9000);
    bus_read(ADDR_PIN_DATA, {16'h0, d});
    bus_write(ADDR_DRIVE_STYLE, 16'h0000);
    // lines as inputs, set by software for the peripheral mode
    bus_write(ADDR_DIRECTION, 16'h0000);
    ext_en <= 16'hFFFF;
    repeat (3) begin
      lfsr = next_rand(lfsr);
      v = lfsr[15:0];
      ext_val <= v;
      settle();
      check_word("peripheral inputs", {22'h0, v[13], v[11], v[9:4], v[2], v[0]}, {22'h0, tap});
      bus_read(ADDR_PIN_DATA, {16'h0, (v & 16'hBFFF) | (d & 16'h4000)});
    end
    ext_en <= 16'h0000;
    bus_write(ADDR_CONTROL, 16'h0003);
    settle();
    check_pins(16'h8000, 16'h8000);
    system_clock_output <= 1'b0;
    settle();
    check_pins(16'h8000, 16'h0000);
    bus_write(ADDR_CONTROL, 16'h0000);
    settle();
    check_pins(16'h1000, 16'h1000);
    hold <= 1'b1;
    settle();
    check_pins(16'h0000, 16'h0000);
    bus_write(ADDR_DIRECTION, 16'h1000);
    bus_write(ADDR_PIN_DATA, 16'h0000);
    settle();
    check_pins(16'h1000, 16'h0000);
    // back to a floating line 12 before hold ends
    bus_write(ADDR_DIRECTION, 16'h0000);
    hold <= 1'b0;
    settle();
    stop_test();
  end
endmodule : port3_io_with_alternate_functions_tb
`default_nettype wire
